/* File: src/pc_stack_pkg.sv */
// Shared constants and types for the program counter and return stack.
package pc_stack_pkg;

   // Widths of the program counter and its parts.
   localparam int PC_W = 13;
   localparam int LOW_W = 8;
   localparam int UPPER_W = 5;
   localparam int LATCH_W = 8;

   // The jump operand covers the low byte plus upper bits 2:0.
   localparam int OPER_W = 11;

   // Holding latch bit positions that feed the upper counter bits.
   localparam int LATCH_LOW_MSB = 4;
   localparam int LATCH_JUMP_MSB = 4;
   localparam int LATCH_JUMP_LSB = 3;

   // Return stack geometry.
   localparam int STACK_DEPTH = 8;
   localparam int STACK_PTR_W = 3;

   // Program counter value type.
   typedef logic [PC_W-1:0] pc_t;

   // Reset values.
   localparam pc_t PC_RESET = 13'h0000;
   localparam logic [LATCH_W-1:0] LATCH_RESET = 8'h00;
   localparam logic [STACK_PTR_W-1:0] PTR_RESET = 3'h0;

   // Default interrupt vector address.
   localparam pc_t INT_VECTOR_DEFAULT = 13'h0004;

   // Low byte value from which an add rolls over to zero.
   localparam logic [LOW_W-1:0] LOW_ALL_ONES = 8'hFF;
   localparam logic [LOW_W-1:0] LOW_ZERO = 8'h00;

   // Next sequential address; wraps at the top of the 13-bit space.
   function automatic pc_t pc_plus_one(input pc_t pc);
      pc_plus_one = pc + 13'h0001;
   endfunction

endpackage

/* File: src/stack_if.sv */
// Push and pop signals between the counter and its return stack.
`timescale 1ns/1ps
interface stack_if;
   import pc_stack_pkg::*;

   // Requests from the counter side.
   logic push;
   logic pop;
   pc_t push_data;

   // Entry that a pop would return.
   pc_t top_data;

   modport owner(output push, output pop, output push_data, input top_data);
   modport store(input push, input pop, input push_data, output top_data);
endinterface

/* File: src/pc_return_stack.sv */
// Circular hardware return stack with a hidden pointer.
`timescale 1ns/1ps
module pc_return_stack
   import pc_stack_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH,
   parameter int PTR_BITS = STACK_PTR_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Counter side
   stack_if.store stk
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage and pointer.

   pc_t mem [DEPTH];
   logic [PTR_BITS-1:0] ptr_reg;
   wire logic [PTR_BITS-1:0] ptr_inc = ptr_reg + 1'h1;
   wire logic [PTR_BITS-1:0] ptr_dec = ptr_reg - 1'h1;
   wire logic [PTR_BITS-1:0] ptr_next = stk.push ? ptr_inc : (stk.pop ? ptr_dec : ptr_reg);

   // The pointer names the next free slot, so the top sits one below it.
   assign stk.top_data = mem[ptr_dec];

   // Pointer wraps modulo the depth in both directions, and nothing flags it.
   always_ff @(posedge clk or posedge rst) begin // see (RL11) see (RL13) see (RL12)
      if (rst) begin
         ptr_reg <= PTR_RESET;
      end else begin
         ptr_reg <= ptr_next;
      end
   end

   // A push writes the free slot; once full it silently overwrites the oldest.
   always_ff @(posedge clk or posedge rst) begin // see (RL11)
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= PC_RESET;
         end
      end else if (stk.push) begin
         mem[ptr_reg] <= stk.push_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   push_pop_pair_a: assert property ( // see (RL9)
      stk.push ##1 (stk.pop && !stk.push) |-> stk.top_data == $past(stk.push_data))
      else $error("pop did not return the value just pushed");

   ptr_wrap_a: assert property ( // see (RL11)
      stk.push [*8] |=> ptr_reg == $past(ptr_reg, 8))
      else $error("pointer did not wrap after eight pushes");

   pop_wrap_a: assert property ( // see (RL13)
      (stk.pop && !stk.push) |=> ptr_reg == $past(ptr_dec))
      else $error("pop did not step the pointer down by one");

   ninth_push_c: cover property (stk.push [*8] ##1 stk.push);

endmodule

/* File: src/pc_sequencer.sv */
// Program counter with high holding latch, driving the return stack.
`timescale 1ns/1ps
//
// Overview of operation
// (RL1) The counter is 13 bits wide and its low byte is a data register read and written.
// (RL2) The upper five bits cannot be read or written directly, only loaded from the latch.
// (RL3) Any reset clears the whole counter to zero.
// (RL4) A write to the low byte loads the upper bits from latch bits 4:0 in the same cycle.
// (RL5) Call and goto take low byte and upper bits 2:0 from the operand, bits 4:3 from the latch.
// (RL6) An add that rolls the low byte past all ones gives no carry into the upper bits.
// (RL7) An eight-entry, 13-bit return stack has a pointer that instructions cannot reach.
// (RL8) Calls and interrupt vectoring push the counter onto the stack.
// (RL9) Plain return, return with literal and return from interrupt pop the stack.
// (RL10) Pushes and pops leave the holding latch unchanged.
// (RL11) The stack is circular, so the ninth push overwrites the first.
// (RL12) No status flag reports stack overflow or underflow.
// (RL13) Pops step the pointer down modulo eight and wrap without any error.
//
module pc_sequencer
   import pc_stack_pkg::*;
#(
   parameter pc_t INT_VECTOR = INT_VECTOR_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Sequencing strobes from the instruction decoder
   input wire logic pc_advance,
   input wire logic int_branch,
   // Call and goto
   input wire logic jump,
   input wire logic jump_is_call,
   input wire logic [OPER_W-1:0] jump_target,
   // Returns of all three kinds
   input wire logic ret_plain,
   input wire logic return_with_literal,
   input wire logic return_from_interrupt,
   // Data writes to the low byte, including add_work_to_file results
   input wire logic low_write,
   input wire logic [LOW_W-1:0] low_wdata,
   // Data writes to the holding latch
   input wire logic latch_write,
   input wire logic [LATCH_W-1:0] latch_wdata,
   // Fetch address and data read values
   output logic [PC_W-1:0] pc_addr,
   output logic [LOW_W-1:0] pc_low_rdata,
   output logic [LATCH_W-1:0] latch_rdata
);

   ////////////////////////////////////////////////////////////////////////////
   // State.

   logic [LOW_W-1:0] pc_low_byte_reg;
   logic [UPPER_W-1:0] pc_upper_bits_reg;
   logic [LATCH_W-1:0] pc_high_holding_latch_reg;

   stack_if stk();

   // Current counter as one word.
   wire pc_t pc_cur = {pc_upper_bits_reg, pc_low_byte_reg};

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the decoder strobes, highest priority first.

   // All three return flavours behave the same here; the literal and the
   // interrupt enable are handled by the decoder and interrupt logic.
   wire logic ret_any = ret_plain | return_with_literal | return_from_interrupt;

   // Vectoring wins over everything, since the decoder is then discarding the
   // instruction in flight; a jump wins over a return in the same cycle.
   wire logic int_sel = int_branch;
   wire logic jump_sel = jump & ~int_sel;
   wire logic call_sel = jump_sel & jump_is_call;
   wire logic ret_sel = ret_any & ~int_sel & ~jump_sel;
   wire logic low_sel = low_write & ~int_sel & ~jump_sel & ~ret_sel;
   wire logic adv_sel = pc_advance & ~int_sel & ~jump_sel & ~ret_sel & ~low_sel;

   ////////////////////////////////////////////////////////////////////////////
   // Candidate next addresses.

   // Sequential fetch.
   wire pc_t pc_inc = pc_plus_one(pc_cur);

   // Page bits of a jump come from the latch, the rest from the operand.
   wire logic [1:0] jump_page = pc_high_holding_latch_reg[LATCH_JUMP_MSB:LATCH_JUMP_LSB];
   wire pc_t jump_pc = {jump_page, jump_target}; // see (RL5)

   // A low byte write replaces all 13 bits at once; the written byte is the
   // ALU result, so an add past all ones simply leaves the latch bits on top.
   wire logic [UPPER_W-1:0] low_page = pc_high_holding_latch_reg[LATCH_LOW_MSB:0];
   wire pc_t low_pc = {low_page, low_wdata}; // see (RL4) see (RL6)

   // Selected next value of the whole counter.
   wire pc_t pc_next = int_sel ? INT_VECTOR :
                       jump_sel ? jump_pc :
                       ret_sel ? stk.top_data :
                       low_sel ? low_pc :
                       adv_sel ? pc_inc : pc_cur;

   ////////////////////////////////////////////////////////////////////////////
   // Stack requests.

   // A call saves the address after itself; an interrupt saves the address of
   // the instruction it pre-empts, so that instruction runs after the return.
   assign stk.push = int_sel | call_sel; // see (RL8)
   assign stk.push_data = int_sel ? pc_cur : pc_inc; // see (RL8)
   assign stk.pop = ret_sel; // see (RL9)

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   // The counter itself; reset of any source clears every bit.
   always_ff @(posedge clk or posedge rst) begin // see (RL3)
      if (rst) begin
         pc_low_byte_reg <= PC_RESET[LOW_W-1:0];
         pc_upper_bits_reg <= PC_RESET[PC_W-1:LOW_W];
      end else begin
         pc_low_byte_reg <= pc_next[LOW_W-1:0]; // see (RL1)
         pc_upper_bits_reg <= pc_next[PC_W-1:LOW_W]; // see (RL2)
      end
   end

   // The latch changes only on its own data write, never on a push or a pop.
   always_ff @(posedge clk or posedge rst) begin // see (RL10)
      if (rst) begin
         pc_high_holding_latch_reg <= LATCH_RESET;
      end else if (latch_write) begin
         pc_high_holding_latch_reg <= latch_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Return stack; its pointer is hidden inside and no flag leaves it.

   pc_return_stack #(
      .DEPTH(STACK_DEPTH),
      .PTR_BITS(STACK_PTR_W)
   ) u_stack (
      .clk(clk),
      .rst(rst),
      .stk(stk.store)
   ); // see (RL7) see (RL12)

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, taken straight from the registers.

   // The upper bits reach only the fetch address, never a data read port.
   assign pc_addr = pc_cur; // see (RL2)
   assign pc_low_rdata = pc_low_byte_reg; // see (RL1)
   assign latch_rdata = pc_high_holding_latch_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Leaving reset, the counter starts from zero.
   pc_reset_a: assert property ($fell(rst) |-> pc_addr == PC_RESET) // see (RL3)
      else $error("counter not cleared by reset");

   // A low byte write lands all 13 bits together in the next cycle.
   low_write_load_a: assert property ( // see (RL4)
      low_sel |=> pc_addr == {$past(pc_high_holding_latch_reg[LATCH_LOW_MSB:0]),
                              $past(low_wdata)})
      else $error("low byte write did not load the page from the latch");

   // Jumps mix operand and latch page bits.
   jump_load_a: assert property ( // see (RL5)
      jump_sel |=> (pc_addr[OPER_W-1:0] == $past(jump_target)) &&
                   (pc_addr[PC_W-1:OPER_W] ==
                    $past(pc_high_holding_latch_reg[LATCH_JUMP_MSB:LATCH_JUMP_LSB])))
      else $error("jump address not formed from operand and latch");

   // A rollover of the low byte keeps the page bits of the latch.
   no_carry_a: assert property ( // see (RL6)
      (low_sel && pc_low_byte_reg == LOW_ALL_ONES && low_wdata == LOW_ZERO)
      |=> pc_upper_bits_reg == $past(pc_high_holding_latch_reg[LATCH_LOW_MSB:0]))
      else $error("low byte rollover carried into the upper bits");

   // A call immediately followed by a return comes back after the call.
   call_return_a: assert property ( // see (RL8) see (RL9)
      call_sel ##1 ret_sel |=> pc_addr == pc_plus_one($past(pc_addr, 2)))
      else $error("return did not resume after the call");

   // Vectoring goes to the vector and the return resumes the pre-empted code.
   int_vector_a: assert property ( // see (RL8)
      int_sel ##1 (ret_sel && !latch_write)
      |=> pc_addr == $past(pc_addr, 2))
      else $error("interrupt return did not resume the pre-empted address");

   int_target_a: assert property (int_sel |=> pc_addr == INT_VECTOR) // see (RL8)
      else $error("interrupt did not branch to the vector");

   // Stack traffic never touches the latch.
   latch_kept_a: assert property ( // see (RL10)
      ((stk.push || stk.pop) && !latch_write) |=> $stable(pc_high_holding_latch_reg))
      else $error("stack operation changed the holding latch");

   // Without any strobe the counter holds.
   pc_hold_a: assert property ( // see (RL1)
      !(int_sel || jump_sel || ret_sel || low_sel || adv_sel) |=> $stable(pc_addr))
      else $error("counter moved with no strobe");

   // Sequential fetch steps by one, wrapping within 13 bits.
   pc_step_a: assert property ( // see (RL1)
      adv_sel |=> pc_addr == pc_plus_one($past(pc_addr)))
      else $error("sequential fetch did not step by one");

   // Main scenarios.
   call_return_c: cover property (call_sel ##[1:20] ret_sel);
   int_return_c: cover property (int_sel ##[1:20] (ret_sel && return_from_interrupt));
   rollover_c: cover property (low_sel && pc_low_byte_reg == LOW_ALL_ONES &&
                               low_wdata == LOW_ZERO);
   literal_return_c: cover property (call_sel ##1 (ret_sel && return_with_literal));

endmodule

/* File: tb/tb_op_pkg.sv */
// Operation codes that the bench hands to the decoder model.
package tb_op_pkg;
   typedef enum logic [3:0] {
      OP_IDLE, OP_ADV, OP_INT, OP_CALL, OP_GOTO, OP_RET, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT, OP_LOWW, OP_LATW
   } op_e;
endpackage

/* File: tb/pc_decoder_model.sv */
// Behavioural instruction decoder that turns one operation code into counter strobes.
`timescale 1ns/1ps
module pc_decoder_model
   import pc_stack_pkg::*;
   import tb_op_pkg::*;
(
   // Operation from the bench
   input wire op_e op,
   input wire logic [OPER_W-1:0] arg,
   // Strobes toward the counter
   output logic pc_advance,
   output logic int_branch,
   output logic jump,
   output logic jump_is_call,
   output logic [OPER_W-1:0] jump_target,
   output logic ret_plain,
   output logic return_with_literal,
   output logic return_from_interrupt,
   output logic low_write,
   output logic [LOW_W-1:0] low_wdata,
   output logic latch_write,
   output logic [LATCH_W-1:0] latch_wdata
);
   // One strobe per operation, so no priority case is ever relied upon.
   assign pc_advance = (op == OP_ADV);
   assign int_branch = (op == OP_INT);
   assign jump = (op == OP_CALL) || (op == OP_GOTO);
   assign jump_is_call = (op == OP_CALL);
   assign ret_plain = (op == OP_RET);
   assign return_with_literal = (op == OP_RETURN_WITH_LITERAL);
   assign return_from_interrupt = (op == OP_RETURN_FROM_INTERRUPT);
   assign low_write = (op == OP_LOWW);
   assign latch_write = (op == OP_LATW);
   // Unqualified data buses carry the inverse, so stale values cannot pass by luck.
   assign jump_target = jump ? arg : ~arg;
   assign low_wdata = low_write ? arg[LOW_W-1:0] : ~arg[LOW_W-1:0];
   assign latch_wdata = latch_write ? arg[LATCH_W-1:0] : ~arg[LATCH_W-1:0];
endmodule

/* File: tb/program_counter_and_call_stack_tb_top.sv */
// Self-checking bench for the program counter and its return stack.
`timescale 1ns/1ps
module program_counter_and_call_stack_tb_top
   import pc_stack_pkg::*;
   import tb_op_pkg::*;
;
   typedef struct {op_e op; logic [10:0] arg; pc_t pc; logic [7:0] lat;} row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   op_e op = OP_IDLE;
   logic [OPER_W-1:0] arg = 11'h000;
   logic pc_advance, int_branch, jump, jump_is_call, ret_plain;
   logic return_with_literal, return_from_interrupt, low_write, latch_write;
   logic [OPER_W-1:0] jump_target;
   logic [LOW_W-1:0] low_wdata, pc_low_rdata;
   logic [LATCH_W-1:0] latch_wdata, latch_rdata;
   logic [PC_W-1:0] pc_addr;
   int num_errors = 0;
   int checks_done = 0;
   pc_t pushed [1:9];
   // Ordinary sequence: expected counter and latch after each operation.
   row_s rows [13] = '{
      '{OP_LATW, 11'h01F, 13'h0000, 8'h1F}, '{OP_LOWW, 11'h034, 13'h1F34, 8'h1F},
      '{OP_ADV, 11'h000, 13'h1F35, 8'h1F}, '{OP_LOWW, 11'h0FF, 13'h1FFF, 8'h1F},
      '{OP_LOWW, 11'h000, 13'h1F00, 8'h1F}, '{OP_LATW, 11'h008, 13'h1F00, 8'h08},
      '{OP_CALL, 11'h123, 13'h0923, 8'h08}, '{OP_GOTO, 11'h7FF, 13'h0FFF, 8'h08},
      '{OP_INT, 11'h000, 13'h0004, 8'h08}, '{OP_RETURN_FROM_INTERRUPT, 11'h000, 13'h0FFF, 8'h08},
      '{OP_RETURN_WITH_LITERAL, 11'h000, 13'h1F01, 8'h08}, '{OP_CALL, 11'h000, 13'h0800, 8'h08},
      '{OP_RET, 11'h000, 13'h1F02, 8'h08}};

   ////////////////////////////////////////////////////////////////////////////////
   // Clock of 8 ns period.
   initial begin
      forever #4 clk = ~clk;
   end

   pc_decoder_model partner (.op(op), .arg(arg), .pc_advance(pc_advance),
      .int_branch(int_branch), .jump(jump), .jump_is_call(jump_is_call),
      .jump_target(jump_target), .ret_plain(ret_plain),
      .return_with_literal(return_with_literal),
      .return_from_interrupt(return_from_interrupt), .low_write(low_write),
      .low_wdata(low_wdata), .latch_write(latch_write), .latch_wdata(latch_wdata));

   pc_sequencer uut (.clk(clk), .rst(rst), .pc_advance(pc_advance),
      .int_branch(int_branch), .jump(jump), .jump_is_call(jump_is_call),
      .jump_target(jump_target), .ret_plain(ret_plain),
      .return_with_literal(return_with_literal),
      .return_from_interrupt(return_from_interrupt), .low_write(low_write),
      .low_wdata(low_wdata), .latch_write(latch_write), .latch_wdata(latch_wdata),
      .pc_addr(pc_addr), .pc_low_rdata(pc_low_rdata), .latch_rdata(latch_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then stops the run.
   task automatic test_done();
      $display("checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Compares all three outputs with the expected counter and latch.
   task automatic check(input pc_t exp_pc, input logic [7:0] exp_lat);
      checks_done++;
      if (pc_addr !== exp_pc || pc_low_rdata !== exp_pc[7:0] || latch_rdata !== exp_lat) begin
         num_errors++;
         $display("Error at %0t: pc %h latch %h, expected %h %h", $time, pc_addr,
            latch_rdata, exp_pc, exp_lat);
      end
   endtask

   // Presents one operation at the falling edge and checks just after the taking edge.
   task automatic run(input op_e o, input logic [10:0] a, input pc_t exp_pc,
         input logic [7:0] exp_lat);
      @(negedge clk);
      op = o;
      arg = a;
      @(posedge clk);
      #1;
      check(exp_pc, exp_lat);
   endtask

   // Holds reset for four cycles and checks the cleared state during it.
   task automatic apply_reset();
      @(negedge clk);
      op = OP_IDLE;
      rst = 1'b1;
      repeat (4) @(negedge clk);
      check(13'h0000, 8'h00);
      rst = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: table rows, then circular stack wrap, then a reset in mid-run.
   initial begin
      apply_reset();
      foreach (rows[i]) begin
         run(rows[i].op, rows[i].arg, rows[i].pc, rows[i].lat);
      end
      $display("test table done");
      // Nine back-to-back calls; each pushes the address after the call.
      pushed[1] = 13'h1F03;
      for (int k = 1; k <= 9; k++) begin
         if (k > 1) pushed[k] = 13'h0801 + 13'(16 * (k - 1));
         run(OP_CALL, 11'(16 * k), 13'h0800 + 13'(16 * k), 8'h08);
      end
      // Eight pops return pushes nine down to two; the ninth wraps to push nine.
      for (int j = 1; j <= 9; j++) begin
         run(OP_RET, 11'h000, pushed[(j == 9) ? 9 : 10 - j], 8'h08);
      end
      $display("test stack wrap done");
      run(OP_ADV, 11'h000, pushed[9] + 13'h0001, 8'h08);
      apply_reset();
      @(posedge clk);
      #1;
      check(13'h0000, 8'h00);
      $display("test mid reset done");
      test_done();
   end

   // Watchdog sized well beyond the few dozen cycles the tests need.
   initial begin
      #20000;
      num_errors++;
      $display("Error at %0t: watchdog expired", $time);
      test_done();
   end
endmodule
